// >>> hdl/uatx_pkg.sv
`default_nettype none

package uatx_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] UATX_OFS_CTRL_ONE = 8'h00; // serial_ctrl_reg_one
  localparam logic [7:0] UATX_OFS_CTRL_TWO = 8'h04; // serial_ctrl_reg_two
  localparam logic [7:0] UATX_OFS_STATUS   = 8'h08; // serial_status_reg
  localparam logic [7:0] UATX_OFS_DATA     = 8'h0C; // serial_data_buffer
  localparam logic [7:0] UATX_OFS_BAUD     = 8'h10; // divisor and fraction

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int C1_PORT_EN = 0;  // serial_port_enable
  localparam int C1_WL9     = 1;  // word_length_sel
  localparam int C1_PAR_EN  = 2;  // parity_enable
  localparam int C1_PAR_LO  = 3;  // parity_type_sel, two bits
  localparam int C1_STOP2   = 5;  // stop_count_sel
  localparam int C1_NINTH   = 6;  // tx_ninth_bit
  localparam int C1_ADDR_EN = 7;  // address detect enable
  localparam int C2_TX_EN   = 0;  // tx_enable
  localparam int C2_BRK     = 1;  // break_request
  localparam int C2_IRQ_EN  = 2;  // tx_empty_irq_enable
  localparam int ST_IDLE    = 0;  // tx_idle_flag
  localparam int ST_EMPTY   = 1;  // tx_buffer_empty_flag
  localparam int BD_FRAC_LO = 16; // baud_fraction, three bits

  // ****************************************************************
  // reset values and counts
  // ****************************************************************
  localparam logic [15:0] UATX_DIVISOR_RST = 16'h0010;
  localparam logic [3:0]  UATX_BRK_BITS    = 4'hD;   // zero bits per break unit
  localparam logic [8:0]  UATX_MASK_WL9    = 9'h0FF; // bits below parity, 9-bit
  localparam logic [8:0]  UATX_MASK_WL8    = 9'h07F; // bits below parity, 8-bit

  // parity type encodings
  typedef enum logic [1:0] {PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE} uatx_par_t;

  // transmitter sequence
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_BREAK, TX_STOP} uatx_state_t;

  // whole block state
  typedef struct packed {
    logic        port_en;
    logic        wl9;
    logic        par_en;
    uatx_par_t   par_type;
    logic        stop2;
    logic        ninth;
    logic        addr_en;
    logic        tx_en;
    logic        brk_req;
    logic        irq_en;
    logic [15:0] divisor;
    logic [2:0]  frac;
    logic [7:0]  buf_data;
    logic        buf_full;
    logic        empty_flag;
    logic        idle_flag;
    logic        armed;
    uatx_state_t st;
    logic        is_brk;
    logic [8:0]  shift;
    logic [3:0]  bit_cnt;
    logic [16:0] timer;
    logic [2:0]  acc;
    logic        brk_armed;
    logic [16:0] brk_cnt;
    logic        tx_line;
    logic [31:0] rdata;
    logic        slverr;
  } uatx_state_s_t;

endpackage : uatx_pkg

`default_nettype wire

// >>> hdl/uatx_top.sv
// Chosen here: the APB slave port and the register addresses.
`default_nettype none

module uatx_top
  import uatx_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // serial line and event
  output var  logic        tx_out,
  output var  logic        tx_irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  uatx_state_s_t s_reg;   // registered state
  uatx_state_s_t s_next;  // next state

  logic        setup;      // apb setup phase
  logic        access;     // apb access phase
  logic        hit;        // address maps to a register
  logic [3:0]  nbits;      // payload bits in a frame
  logic        bit_end;    // current bit time finished
  logic [3:0]  acc_sum;    // fraction accumulator with carry
  logic [8:0]  payload;    // character before parity insert
  logic        par_xor;    // xor of bits below the parity slot
  logic        par_bit;    // chosen parity bit
  logic        can_start;  // transmitter allowed to begin a frame
  logic [16:0] brk_limit;  // divisor plus one

  // ****************************************************************
  // combinational helpers
  // ****************************************************************
  always_comb begin
    setup    = psel & ~penable;
    access   = psel & penable;
    hit      = (paddr == UATX_OFS_CTRL_ONE) | (paddr == UATX_OFS_CTRL_TWO) |
               (paddr == UATX_OFS_STATUS) | (paddr == UATX_OFS_DATA) | (paddr == UATX_OFS_BAUD);
    nbits    = s_reg.wl9 ? 4'h9 : 4'h8;
    bit_end  = (s_reg.timer == 17'h0_0000);
    // accumulate fraction once per bit, carry into bit 3 stretches it
    acc_sum  = {1'b0, s_reg.acc} + {1'b0, s_reg.frac};
    // ninth bit only exists in 9-bit mode
    payload  = {s_reg.wl9 & s_reg.ninth, s_reg.buf_data};
    par_xor  = ^(payload & (s_reg.wl9 ? UATX_MASK_WL9 : UATX_MASK_WL8));
    unique case (s_reg.par_type)
      PAR_ODD:   par_bit = ~par_xor;
      PAR_EVEN:  par_bit = par_xor;
      PAR_MARK:  par_bit = 1'b1;
      PAR_SPACE: par_bit = 1'b0;
    endcase
    // shift timing exists only with a nonzero divisor
    can_start = s_reg.port_en & s_reg.tx_en & (s_reg.divisor != 16'h0000);
    brk_limit = {1'b0, s_reg.divisor} + 17'h0_0001;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_next = s_reg;

    // apb read data is captured in setup so the access phase needs no wait
    if (setup) begin
      s_next.slverr = ~hit;
      s_next.rdata  = 32'h0000_0000;
      unique case (paddr)
        UATX_OFS_CTRL_ONE: begin
          s_next.rdata[C1_PORT_EN]           = s_reg.port_en;
          s_next.rdata[C1_WL9]               = s_reg.wl9;
          s_next.rdata[C1_PAR_EN]            = s_reg.par_en;
          s_next.rdata[C1_PAR_LO +: 2]       = s_reg.par_type;
          s_next.rdata[C1_STOP2]             = s_reg.stop2;
          s_next.rdata[C1_NINTH]             = s_reg.ninth;
          s_next.rdata[C1_ADDR_EN]           = s_reg.addr_en;
        end
        UATX_OFS_CTRL_TWO: begin
          s_next.rdata[C2_TX_EN]             = s_reg.tx_en;
          s_next.rdata[C2_BRK]               = s_reg.brk_req;
          s_next.rdata[C2_IRQ_EN]            = s_reg.irq_en;
        end
        UATX_OFS_STATUS: begin
          s_next.rdata[ST_IDLE]              = s_reg.idle_flag;
          s_next.rdata[ST_EMPTY]             = s_reg.empty_flag;
        end
        UATX_OFS_DATA: begin
          s_next.rdata[7:0]                  = s_reg.buf_data;
        end
        UATX_OFS_BAUD: begin
          s_next.rdata[15:0]                 = s_reg.divisor;
          s_next.rdata[BD_FRAC_LO +: 3]      = s_reg.frac;
        end
        default: begin
          s_next.rdata = 32'h0000_0000;  // unmapped reads zero with error
        end
      endcase
    end

    // apb access phase: writes and side effects take place here
    if (access && hit) begin
      if (paddr == UATX_OFS_STATUS) begin
        s_next.armed = 1'b1;
      end
      if (pwrite) begin
        unique case (paddr)
          UATX_OFS_CTRL_ONE: begin
            s_next.port_en  = pwdata[C1_PORT_EN];
            s_next.wl9      = pwdata[C1_WL9];
            s_next.par_en   = pwdata[C1_PAR_EN];
            s_next.par_type = uatx_par_t'(pwdata[C1_PAR_LO +: 2]);
            s_next.stop2    = pwdata[C1_STOP2];
            s_next.ninth    = pwdata[C1_NINTH];
            s_next.addr_en  = pwdata[C1_ADDR_EN];
          end
          UATX_OFS_CTRL_TWO: begin
            s_next.tx_en    = pwdata[C2_TX_EN];
            s_next.brk_req  = pwdata[C2_BRK];
            s_next.irq_en   = pwdata[C2_IRQ_EN];
          end
          UATX_OFS_DATA: begin
            // a write only counts after a status access and with room free
            if (s_reg.armed && s_reg.empty_flag) begin
              s_next.buf_data   = pwdata[7:0];
              s_next.buf_full   = 1'b1;
              s_next.empty_flag = 1'b0;
              s_next.idle_flag  = 1'b0;
              s_next.armed      = 1'b0;
            end
          end
          UATX_OFS_BAUD: begin
            s_next.divisor = pwdata[15:0];
            s_next.frac    = pwdata[BD_FRAC_LO +: 3];
          end
          default: begin
            s_next.armed = s_next.armed; // status is read only
          end
        endcase
      end
    end

    // break request must be seen high long enough while the line is idle
    if (s_reg.brk_req && s_reg.idle_flag && (s_reg.st == TX_IDLE)) begin
      if (s_reg.brk_cnt != 17'h1_FFFF) begin
        s_next.brk_cnt = s_reg.brk_cnt + 17'h0_0001;
      end
      if (s_reg.brk_cnt > brk_limit) begin
        s_next.brk_armed = 1'b1;
      end
    end else if (!s_reg.brk_req) begin
      s_next.brk_cnt   = 17'h0_0000;
      s_next.brk_armed = 1'b0;
    end

    // bit timer runs down inside a frame
    if (s_reg.st != TX_IDLE && !bit_end) begin
      s_next.timer = s_reg.timer - 17'h0_0001;
    end

    // frame sequencer
    unique case (s_reg.st)
      TX_IDLE: begin
        s_next.tx_line = 1'b1;
      end
      TX_START: begin
        s_next.tx_line = 1'b0;
        if (bit_end) begin
          s_next.st      = s_reg.is_brk ? TX_BREAK : TX_DATA;
          s_next.bit_cnt = 4'h0;
          s_next.tx_line = s_reg.is_brk ? 1'b0 : s_reg.shift[0];
        end
      end
      TX_DATA: begin
        if (bit_end) begin
          s_next.shift   = {1'b0, s_reg.shift[8:1]};
          s_next.tx_line = s_reg.shift[1];
          s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          if (s_reg.bit_cnt == nbits - 4'h1) begin
            s_next.st      = TX_STOP;
            s_next.bit_cnt = 4'h0;
            s_next.tx_line = 1'b1;
          end
        end
      end
      TX_BREAK: begin
        s_next.tx_line = 1'b0;
        if (bit_end) begin
          s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          if (s_reg.bit_cnt == UATX_BRK_BITS - 4'h1) begin
            s_next.bit_cnt = 4'h0;
            if (!s_reg.brk_req) begin
              s_next.st      = TX_STOP;
              s_next.tx_line = 1'b1;
            end
          end
        end
      end
      TX_STOP: begin
        s_next.tx_line = 1'b1;
        if (bit_end) begin
          if (s_reg.stop2 && s_reg.bit_cnt == 4'h0) begin
            s_next.bit_cnt = 4'h1;
          end else begin
            // frame done; a set here wins over a clear in the same cycle
            s_next.st        = TX_IDLE;
            s_next.idle_flag = 1'b1;
            s_next.is_brk    = 1'b0;
          end
        end
      end
      default: begin
        s_next.st = TX_IDLE;
      end
    endcase

    // start a new bit time: reload timer, stretch on fraction carry
    if (s_reg.st != TX_IDLE && bit_end && s_next.st != TX_IDLE) begin
      s_next.acc   = acc_sum[2:0];
      s_next.timer = {1'b0, s_reg.divisor} - 17'h0_0001 + {16'h0000, acc_sum[3]};
    end

    // frame launch; also runs right after the last stop bit ends
    if (s_next.st == TX_IDLE && can_start) begin
      if (s_reg.brk_armed && s_reg.brk_req) begin
        // break frames leave the buffer and its empty flag untouched
        s_next.st        = TX_START;
        s_next.is_brk    = 1'b1;
        s_next.brk_armed = 1'b0;
        s_next.tx_line   = 1'b0;
        s_next.acc       = acc_sum[2:0];
        s_next.timer     = {1'b0, s_reg.divisor} - 17'h0_0001 + {16'h0000, acc_sum[3]};
      end else if (s_reg.buf_full) begin
        s_next.st         = TX_START;
        s_next.is_brk     = 1'b0;
        s_next.shift      = payload;
        if (s_reg.par_en) begin
          s_next.shift[nbits - 4'h1] = par_bit;
        end
        s_next.buf_full   = 1'b0;
        s_next.empty_flag = 1'b1;
        s_next.tx_line    = 1'b0;
        s_next.acc        = acc_sum[2:0];
        s_next.timer      = {1'b0, s_reg.divisor} - 17'h0_0001 + {16'h0000, acc_sum[3]};
      end
    end

    // dropping tx enable aborts the frame; buffered byte stays
    if (!s_next.tx_en) begin
      s_next.st        = TX_IDLE;
      s_next.is_brk    = 1'b0;
      s_next.bit_cnt   = 4'h0;
      s_next.timer     = 17'h0_0000;
      s_next.acc       = 3'h0;
      s_next.tx_line   = 1'b1;
      s_next.brk_armed = 1'b0;
    end

    // whole port off: flush, drop tx enable and break request, raise both flags
    if (!s_next.port_en) begin
      s_next.buf_full   = 1'b0;
      s_next.tx_en      = 1'b0;
      s_next.brk_req    = 1'b0;
      s_next.empty_flag = 1'b1;
      s_next.idle_flag  = 1'b1;
      s_next.st         = TX_IDLE;
      s_next.is_brk     = 1'b0;
      s_next.tx_line    = 1'b1;
      s_next.armed      = 1'b0;
      s_next.brk_cnt    = 17'h0_0000;
      s_next.brk_armed  = 1'b0;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg            <= '0;
      s_reg.par_type   <= PAR_ODD;
      s_reg.st         <= TX_IDLE;
      s_reg.divisor    <= UATX_DIVISOR_RST;
      s_reg.empty_flag <= 1'b1;
      s_reg.idle_flag  <= 1'b1;
      s_reg.tx_line    <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_comb begin
    prdata  = s_reg.rdata;
    pready  = 1'b1;                  // zero wait states
    pslverr = access & s_reg.slverr;
    tx_out  = s_reg.tx_line;
    // break frames never set the empty flag, so they raise no event
    tx_irq  = s_reg.empty_flag & s_reg.irq_en;
  end

endmodule : uatx_top

`default_nettype wire

// >>> tb/uatx_chk.sv
`default_nettype none

module uatx_chk
  import uatx_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // line and event
  input wire logic        tx_out,
  input wire logic        tx_irq
);
  // ********
  // shadow of written control fields
  // ********
  logic        pen;    // port enable
  logic        ten;    // transmit enable
  logic        ie;     // empty event enable
  logic [15:0] div;    // bit period
  logic        tx_q;   // line one sample back
  logic [16:0] run;    // samples since the line moved
  logic        wr_ok;  // write lands this edge
  logic        map_ok; // address hits a register
  assign wr_ok  = psel && penable && pwrite;
  assign map_ok = paddr inside {UATX_OFS_CTRL_ONE, UATX_OFS_CTRL_TWO, UATX_OFS_STATUS, UATX_OFS_DATA,
                                UATX_OFS_BAUD};
  // port disable drops transmit enable too, so the shadow follows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pen  <= 1'h0;
      ten  <= 1'h0;
      ie   <= 1'h0;
      div  <= UATX_DIVISOR_RST;
      tx_q <= 1'h1;
      run  <= 17'h0;
    end else begin
      tx_q <= tx_out;
      run  <= (tx_out != tx_q) ? 17'h0 : run + 17'h1;
      if (wr_ok && paddr == UATX_OFS_CTRL_ONE) begin
        pen <= pwdata[C1_PORT_EN];
        ten <= ten & pwdata[C1_PORT_EN];
      end
      if (wr_ok && paddr == UATX_OFS_CTRL_TWO) begin
        ten <= pwdata[C2_TX_EN];
        ie  <= pwdata[C2_IRQ_EN];
      end
      if (wr_ok && paddr == UATX_OFS_BAUD) div <= pwdata[15:0];
    end
  end
  // ********
  // properties
  // ********
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // two samples of slack cover a one-cycle output register
  sequence s_low2(x);
    !x ##1 !x;
  endsequence
  sequence s_dis;
    (ie && !pen) ##1 (ie && !pen);
  endsequence
  tx_dis_a: assert property (s_low2(ten) |-> tx_out)
    else $error("line low with transmit disabled");
  port_dis_a: assert property (s_low2(pen) |-> tx_out)
    else $error("line low with port disabled");
  div_zero_a: assert property ((div == 16'h0) ##1 (div == 16'h0) |-> tx_out)
    else $error("line moved with zero divisor");
  run_len_a: assert property ((tx_out != tx_q) && pen && ten |-> run + 17'h1 >= {1'h0, div})
    else $error("bit shorter than divisor");
  irq_mask_a: assert property (s_low2(ie) |-> !tx_irq)
    else $error("event raised while masked");
  irq_dis_a: assert property (s_dis |-> tx_irq)
    else $error("empty event missing after port disable");
  err_map_a: assert property (psel && penable && !map_ok |-> pslverr)
    else $error("unmapped access not refused");
  ok_map_a: assert property (psel && penable && map_ok |-> !pslverr && pready)
    else $error("mapped access refused");
  rd_zero_a: assert property (psel && penable && !pwrite && !map_ok |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : uatx_chk

`default_nettype wire

// >>> tb/uatx_rx_model.sv
`default_nettype none

module uatx_rx_model (
  // clock, reset, line
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tx_out,
  // frame shape set by the bench
  input  wire logic [4:0]  nb,
  input  wire logic [15:0] div,
  // last frame and frame count
  output var  logic [15:0] rx_bits,
  output var  logic [7:0]  rx_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // mid-bit sampling receiver, whole periods only
  // ********
  initial begin : rx_loop
    logic [15:0] v; // frame under way
    rx_bits = 16'hFFFF;
    rx_cnt  = 8'h0;
    forever begin
      @(posedge pclk);
      if (presetn && tx_out === 1'h0) begin // start edge
        v = 16'hFFFF;
        repeat (div / 2) @(posedge pclk);
        for (int i = 0; i < nb; i++) begin
          repeat (div) @(posedge pclk);
          v[i] = tx_out;
        end
        rx_bits = v;
        rx_cnt++;
        // no start is hunted until the line rests high again
        while (tx_out !== 1'h1) @(posedge pclk);
      end
    end
  end
endmodule : uatx_rx_model

`default_nettype wire

// >>> tb/uatx_tb_top.sv
`default_nettype none

module uatx_tb_top
  import uatx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // signals
  // ********
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tx_out;
  logic        tx_irq;
  logic [4:0]  nb = 5'hA;      // model: bits after start
  logic [15:0] mdiv = 16'h8;   // model: bit period
  logic [15:0] rx_bits;        // last frame decoded
  logic [7:0]  rx_cnt;         // frames decoded
  logic [7:0]  exp_cnt = 8'h0; // frames expected
  logic [31:0] q;              // last read data
  int          cyc = 0;        // cycle count
  int          n_errors = 0;
  int          compares = 0;
  logic [7:0]  cfg [6] = '{8'h01, 8'h05, 8'h0D, 8'h37, 8'h5F, 8'hE3}; // frame formats

  always #50 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  uatx_top uatx_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_out(tx_out), .tx_irq(tx_irq));
  uatx_rx_model uatx_rx_model_i (.pclk(pclk), .presetn(presetn), .tx_out(tx_out), .nb(nb), .div(mdiv),
    .rx_bits(rx_bits), .rx_cnt(rx_cnt));

  // ********
  // shared tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one transfer; the extra edge keeps two calls from colliding
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'h1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(a, 1'h0, 32'h0);
  endtask : rd
  task automatic send(input logic [7:0] d);
    rd(UATX_OFS_STATUS);
    wr(UATX_OFS_DATA, {24'h0, d});
  endtask : send
  task automatic wait_lvl(input logic l);
    int k;
    k = 0;
    while (tx_out !== l && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    // a level that never comes is a hang, counted as a mismatch
    chk("line_wait", {31'h0, l}, {31'h0, tx_out});
  endtask : wait_lvl
  task automatic get_frame(input logic [15:0] e);
    int k;
    exp_cnt++;
    k = 0;
    while (rx_cnt !== exp_cnt && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    // a frame that never arrives must not pass on stale data
    chk("frame_count", {24'h0, exp_cnt}, {24'h0, rx_cnt});
    chk("frame", {16'h0, e}, {16'h0, rx_bits});
  endtask : get_frame
  // expected line bits after start, stop bits as trailing ones
  function automatic logic [15:0] fbits(input logic [7:0] c, input logic [7:0] d);
    logic [8:0] v;
    logic [8:0] m;
    int         n;
    n = c[C1_WL9] ? 9 : 8;
    m = (9'h1 << (n - 1)) - 9'h1;
    v = {c[C1_NINTH], d};
    if (c[C1_PAR_EN]) v[n - 1] = (c[4:3] == 2'h0) ? ~^(v & m) : (c[4:3] == 2'h1) ? ^(v & m) : ~c[3];
    fbits = 16'hFFFF;
    for (int i = 0; i < n; i++) fbits[i] = v[i];
    nb = 5'(n + 1 + c[C1_STOP2]);
  endfunction : fbits

  // ********
  // scenarios
  // ********
  task automatic t_reset();
    rd(UATX_OFS_STATUS);
    chk("status", 32'h3, q);
    chk("tx_out", 32'h1, {31'h0, tx_out});
    wr(UATX_OFS_CTRL_ONE, 32'h1);
    wr(UATX_OFS_CTRL_TWO, 32'h4);
    wr(UATX_OFS_CTRL_ONE, 32'h0);
    chk("tx_irq", 32'h1, {31'h0, tx_irq});
    rd(8'h14);
    chk("unmapped", 32'h0, q);
    wr(8'h14, 32'hFFFF_FFFF);
    wr(UATX_OFS_BAUD, 32'h0);
    repeat (2) @(posedge pclk);
  endtask : t_reset
  task automatic t_formats();
    logic [15:0] e0;
    logic [15:0] e1;
    logic [7:0]  d;
    wr(UATX_OFS_CTRL_ONE, 32'h1);
    wr(UATX_OFS_BAUD, 32'h8);
    wr(UATX_OFS_CTRL_TWO, 32'h1);
    for (int i = 0; i < 6; i++) begin
      wr(UATX_OFS_CTRL_ONE, {24'h0, cfg[i]});
      rd(UATX_OFS_CTRL_ONE);
      chk("ctrl_one", {24'h0, cfg[i]}, q);
      d  = 8'hA5 ^ (8'h3C * i[7:0]);
      e0 = fbits(cfg[i], d);
      e1 = fbits(cfg[i], ~d);
      send(d);
      send(~d);
      get_frame(e0);
      get_frame(e1);
    end
  endtask : t_formats
  task automatic t_ignore();
    wr(UATX_OFS_CTRL_ONE, 32'h1);
    send(8'h11);
    wr(UATX_OFS_DATA, 32'h22);
    rd(UATX_OFS_STATUS);
    chk("status", 32'h2, q);
    wr(UATX_OFS_DATA, 32'h33);
    rd(UATX_OFS_STATUS);
    chk("status", 32'h0, q);
    wr(UATX_OFS_DATA, 32'h44);
    get_frame(fbits(8'h01, 8'h11));
    get_frame(fbits(8'h01, 8'h33));
    repeat (300) @(posedge pclk);
    chk("frames", {24'h0, exp_cnt}, {24'h0, rx_cnt});
    rd(UATX_OFS_STATUS);
    chk("status", 32'h3, q);
  endtask : t_ignore
  task automatic t_wfirst();
    wr(UATX_OFS_CTRL_TWO, 32'h0);
    send(8'h5A);
    repeat (100) @(posedge pclk);
    chk("tx_out", 32'h1, {31'h0, tx_out});
    wr(UATX_OFS_CTRL_TWO, 32'h1);
    get_frame(fbits(8'h01, 8'h5A));
  endtask : t_wfirst
  task automatic t_break();
    int t0;
    wr(UATX_OFS_CTRL_TWO, 32'h3);
    wait_lvl(1'h0);
    t0 = cyc;
    repeat (160) @(posedge pclk);
    wr(UATX_OFS_CTRL_TWO, 32'h1);
    wait_lvl(1'h1);
    chk("break_low", (32'h1 + 32'hD * 32'h2) * mdiv, cyc - t0);
    repeat (40) @(posedge pclk);
    rd(UATX_OFS_STATUS);
    chk("status", 32'h3, q);
  endtask : t_break
  task automatic t_abort();
    int k;
    send(8'h00);
    repeat (24) @(posedge pclk);
    chk("tx_out", 32'h0, {31'h0, tx_out});
    wr(UATX_OFS_CTRL_TWO, 32'h0);
    k = 0;
    repeat (2) @(posedge pclk);
    repeat (100) begin
      @(posedge pclk);
      k += (tx_out !== 1'h1);
    end
    chk("abort_low", 32'h0, k);
    wr(UATX_OFS_CTRL_TWO, 32'h1);
  endtask : t_abort
  task automatic t_frac();
    int a;
    int t0;
    wr(UATX_OFS_CTRL_TWO, 32'h0); // clears the fraction accumulator
    wr(UATX_OFS_BAUD, 32'h0003_0008);
    wr(UATX_OFS_CTRL_TWO, 32'h1);
    send(8'h55);
    wait_lvl(1'h0);
    t0 = cyc;
    a = 0;
    for (int b = 0; b < 9; b++) begin
      a = a + 3;
      wait_lvl(~b[0]);
      chk("bit_len", mdiv + (a >= 8), cyc - t0);
      t0 = cyc;
      a = a % 8;
    end
  endtask : t_frac
  task automatic results();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // ********
  // main sequence and watchdog
  // ********
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_formats();
    t_ignore();
    t_wfirst();
    t_break();
    t_abort();
    t_frac();
    results();
  end
  initial begin : watchdog
    repeat (30000) @(posedge pclk);
    n_errors++;
    results();
  end
endmodule : uatx_tb_top

bind uatx_top uatx_chk uatx_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_out(tx_out), .tx_irq(tx_irq));

`default_nettype wire
